// ---- link_param_pkg.sv ----
// Constants shared by the link parameter register bank.
//
// Functional notes
// R1 - Lane-count register bit 7 enables descrambling of received lane data.
// R2 - Lane-count bits 4:0 hold lanes per link minus one.
// R3 - Frame-size register holds octets per frame minus one.
// R4 - Second frame-size register holds octets per frame as plain count.
// R5 - Multiframe bits 4:0 hold frames per multiframe minus one.
// R6 - Software programs 32 frames per multiframe in single-converter two-lane mode.
// R7 - Converter-count register holds converters per link minus one.
// R8 - Software keeps resolution bits 7:6 zero and bits 4:0 at 0x0F.
// R9 - Sample-width bits 7:5 select subclass; bits 4:0 of 0xF mean 16 bits.
// R10 - Version bits 7:5 equal one; bits 4:0 hold samples per frame minus one.
// R11 - Density bit 7 selects high density; control-word count is always zero; the bank neither forces nor checks this, and bits 4:0 pass out as written.
// R12 - Deskew register is a per-lane mask of lanes included in deskew.
// R13 - Lane-enable register is a per-lane mask enabling each link lane.
// R14 - Software writes all parameter registers before the lane-enable mask.
package link_param_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned NUM_REGS = 11;
  localparam logic [14:0] ADDR_LANE_COUNT_SCRAMBLE = 15'h0453;
  localparam logic [14:0] ADDR_FRAME_OCTETS_MINUS_ONE = 15'h0454;
  localparam logic [14:0] ADDR_MULTIFRAME_LENGTH = 15'h0455;
  localparam logic [14:0] ADDR_CONVERTER_COUNT = 15'h0456;
  localparam logic [14:0] ADDR_RESOLUTION_CTRL_BITS = 15'h0457;
  localparam logic [14:0] ADDR_SUBCLASS_SAMPLE_WIDTH = 15'h0458;
  localparam logic [14:0] ADDR_VERSION_SAMPLES_PER_FRAME = 15'h0459;
  localparam logic [14:0] ADDR_DENSITY_CTRL_WORDS = 15'h045A;
  localparam logic [14:0] ADDR_LANE_DESKEW_MASK = 15'h046C;
  localparam logic [14:0] ADDR_FRAME_OCTETS_PLAIN = 15'h0476;
  localparam logic [14:0] ADDR_LANE_ENABLE_MASK = 15'h047D;

  // Register slots in the bank, in map order.
  localparam logic [3:0] IDX_LANE = 4'h0;
  localparam logic [3:0] IDX_FOCT = 4'h1;
  localparam logic [3:0] IDX_MF = 4'h2;
  localparam logic [3:0] IDX_CONV = 4'h3;
  localparam logic [3:0] IDX_RES = 4'h4;
  localparam logic [3:0] IDX_SUB = 4'h5;
  localparam logic [3:0] IDX_VER = 4'h6;
  localparam logic [3:0] IDX_DENS = 4'h7;
  localparam logic [3:0] IDX_DESK = 4'h8;
  localparam logic [3:0] IDX_FPLN = 4'h9;
  localparam logic [3:0] IDX_LEN = 4'hA;

  // Reset value of every register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned SCRAMBLE_BIT = 7;
  localparam int unsigned COUNT_MSB = 4;
  localparam int unsigned HD_BIT = 7;
  localparam int unsigned TOP_MSB = 7;
  localparam int unsigned TOP_LSB = 5;
  localparam int unsigned CS_LSB = 6;
  localparam logic [2:0] VERSION_B = 3'h1;

  // ----------------------------------------
  // Serial port framing
  // ----------------------------------------
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] DATA_LAST = 4'h7;

endpackage : link_param_pkg

// ---- pin_sync.sv ----
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_state_t;

  sync_state_t q, d;

  // Each bit follows the pin once the second and third stages agree.
  always_comb
  begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (q.s2[i] == q.s3[i])
      begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, lvl: RESET_VAL};
    end
    else
    begin
      q <= d;
    end
  end

  assign level_o = q.lvl;

endmodule : pin_sync

// ---- link_param_decode.sv ----
// Turns the stored minus-one fields into plain link parameter counts.
`timescale 1ns/1ps
module link_param_decode (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] lane_reg_i,
  input wire logic [7:0] foct_reg_i,
  input wire logic [7:0] mf_reg_i,
  input wire logic [7:0] conv_reg_i,
  input wire logic [7:0] ver_reg_i,
  input wire logic [7:0] fpln_reg_i,
  output logic [5:0] lanes_o,
  output logic [8:0] octets_o,
  output logic [5:0] frames_o,
  output logic [8:0] converters_o,
  output logic [5:0] samples_o,
  output logic octets_mismatch_o
);

  typedef struct packed {
    logic [5:0] lanes;
    logic [8:0] octets;
    logic [5:0] frames;
    logic [8:0] conv;
    logic [5:0] samp;
    logic mismatch;
  } dec_state_t;

  dec_state_t q, d;

  // Adds one to a five-bit minus-one field.
  function automatic logic [5:0] plus_one5(input logic [4:0] f);
    plus_one5 = {1'b0, f} + 6'h01;
  endfunction : plus_one5

  // Adds one to an eight-bit minus-one field.
  function automatic logic [8:0] plus_one8(input logic [7:0] f);
    plus_one8 = {1'b0, f} + 9'h001;
  endfunction : plus_one8

  // Register the decoded counts and compare both frame-size copies.
  always_comb
  begin
    d = q;
    d.lanes = plus_one5(lane_reg_i[4:0]); // [R2]
    d.octets = plus_one8(foct_reg_i); // [R3]
    d.frames = plus_one5(mf_reg_i[4:0]); // [R5]
    d.conv = plus_one8(conv_reg_i); // [R7]
    d.samp = plus_one5(ver_reg_i[4:0]); // [R10]
    d.mismatch = (plus_one8(foct_reg_i) != {1'b0, fpln_reg_i}); // [R4]
  end

  // State register.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign lanes_o = q.lanes;
  assign octets_o = q.octets;
  assign frames_o = q.frames;
  assign converters_o = q.conv;
  assign samples_o = q.samp;
  assign octets_mismatch_o = q.mismatch;

endmodule : link_param_decode

// ---- serial_link_param_regs.sv ----
// Link parameter register bank reached over the serial configuration port.
`timescale 1ns/1ps
module serial_link_param_regs (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_csb_n_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  output logic descramble_en_o,
  output logic [4:0] lane_count_field_o,
  output logic [7:0] frame_octets_field_o,
  output logic [4:0] multiframe_field_o,
  output logic [7:0] converter_field_o,
  output logic [1:0] ctrl_bits_field_o,
  output logic [4:0] resolution_field_o,
  output logic [2:0] subclass_o,
  output logic [4:0] sample_width_field_o,
  output logic [2:0] version_o,
  output logic version_ok_o,
  output logic [4:0] samples_field_o,
  output logic high_density_o,
  output logic [4:0] ctrl_words_field_o,
  output logic [7:0] frame_octets_plain_o,
  output logic [7:0] deskew_mask_o,
  output logic [7:0] lane_enable_o,
  output logic [5:0] lanes_o,
  output logic [8:0] octets_o,
  output logic [5:0] frames_o,
  output logic [8:0] converters_o,
  output logic [5:0] samples_o,
  output logic octets_mismatch_o
);

  // ----------------------------------------
  // Types and state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b10
  } spi_state_t;

  typedef struct packed {
    spi_state_t state;
    logic sclk_prev;
    logic [3:0] bit_cnt;
    logic rd;
    logic [14:0] addr;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic sdo;
    logic sdo_oe;
    logic [10:0][7:0] regs;
  } bank_state_t;

  bank_state_t q, d;

  logic csb_s;
  logic sclk_s;
  logic sdi_s;
  logic rise;
  logic fall;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------

  // Maps a port address to {hit, slot}; unmapped addresses miss.
  function automatic logic [4:0] slot_of(input logic [14:0] a);
    case (a)
      link_param_pkg::ADDR_LANE_COUNT_SCRAMBLE: slot_of = {1'b1, link_param_pkg::IDX_LANE};
      link_param_pkg::ADDR_FRAME_OCTETS_MINUS_ONE: slot_of = {1'b1, link_param_pkg::IDX_FOCT};
      link_param_pkg::ADDR_MULTIFRAME_LENGTH: slot_of = {1'b1, link_param_pkg::IDX_MF};
      link_param_pkg::ADDR_CONVERTER_COUNT: slot_of = {1'b1, link_param_pkg::IDX_CONV};
      link_param_pkg::ADDR_RESOLUTION_CTRL_BITS: slot_of = {1'b1, link_param_pkg::IDX_RES};
      link_param_pkg::ADDR_SUBCLASS_SAMPLE_WIDTH: slot_of = {1'b1, link_param_pkg::IDX_SUB};
      link_param_pkg::ADDR_VERSION_SAMPLES_PER_FRAME: slot_of = {1'b1, link_param_pkg::IDX_VER};
      link_param_pkg::ADDR_DENSITY_CTRL_WORDS: slot_of = {1'b1, link_param_pkg::IDX_DENS};
      link_param_pkg::ADDR_LANE_DESKEW_MASK: slot_of = {1'b1, link_param_pkg::IDX_DESK};
      link_param_pkg::ADDR_FRAME_OCTETS_PLAIN: slot_of = {1'b1, link_param_pkg::IDX_FPLN};
      link_param_pkg::ADDR_LANE_ENABLE_MASK: slot_of = {1'b1, link_param_pkg::IDX_LEN};
      default: slot_of = 5'h00;
    endcase
  endfunction : slot_of

  // Read data for an address; unmapped addresses read as zero.
  function automatic logic [7:0] read_reg(input logic [10:0][7:0] r, input logic [14:0] a);
    logic [4:0] s;
    s = slot_of(a);
    if (s[4])
    begin
      read_reg = r[s[3:0]];
    end
    else
    begin
      read_reg = 8'h00;
    end
  endfunction : read_reg

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------

  // Five-bit count field in the low bits of a register byte.
  function automatic logic [4:0] low_field(input logic [7:0] r);
    low_field = r[link_param_pkg::COUNT_MSB:0];
  endfunction : low_field

  // Three-bit code field in the top bits of a register byte.
  function automatic logic [2:0] top_field(input logic [7:0] r);
    top_field = r[link_param_pkg::TOP_MSB:link_param_pkg::TOP_LSB];
  endfunction : top_field

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------

  // Chip select idles high, so its filtered level starts high.
  // The filter lags the pins by three to four clocks, so each serial clock phase must outlast it.
  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h4)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i({spi_csb_n_i, spi_sclk_i, spi_sdi_i}),
    .level_o({csb_s, sclk_s, sdi_s})
  );

  // Serial clock edges seen on the filtered level.
  assign rise = sclk_s & ~q.sclk_prev;
  assign fall = ~sclk_s & q.sclk_prev;

  // ----------------------------------------
  // Serial protocol and register file
  // ----------------------------------------

  // A frame is a read/write bit, a 15-bit address and then data bytes,
  // all MSB first on rising serial clock edges. The address steps up by
  // one after each byte, so a burst covers consecutive registers.
  always_comb
  begin
    logic [4:0] slot;
    logic [7:0] byte_in;
    logic [14:0] next_addr;
    slot = 5'h00;
    byte_in = {q.shift_in[6:0], sdi_s};
    next_addr = q.addr + 15'h0001;
    d = q;
    d.sclk_prev = sclk_s;
    if (csb_s)
    begin
      // Deselect ends the frame at once, even mid-byte; a partial byte is dropped.
      d.state = ST_IDLE;
      d.bit_cnt = 4'h0;
      d.sdo = 1'b0;
      d.sdo_oe = 1'b0;
    end
    else
    begin
      if (q.state == ST_IDLE)
      begin
        d.state = ST_INSTR;
      end
      if (rise)
      begin
        case (q.state)
          ST_IDLE, ST_INSTR:
          begin
            // The read flag ends up above the address once sixteen bits are in.
            {d.rd, d.addr} = {q.addr, sdi_s};
            d.bit_cnt = q.bit_cnt + 4'h1;
            // The last address bit has landed: fetch the first byte that a read sends.
            if (q.bit_cnt == link_param_pkg::INSTR_LAST)
            begin
              d.state = ST_DATA;
              d.bit_cnt = 4'h0;
              d.shift_out = read_reg(q.regs, {q.addr[13:0], sdi_s});
            end
          end
          ST_DATA:
          begin
            d.shift_in = byte_in;
            d.bit_cnt = q.bit_cnt + 4'h1;
            // A full byte is in: store it, or fetch the next byte to send.
            if (q.bit_cnt == link_param_pkg::DATA_LAST)
            begin
              d.bit_cnt = 4'h0;
              d.addr = next_addr;
              if (!q.rd)
              begin
                slot = slot_of(q.addr);
                if (slot[4])
                begin
                  // Every field is stored exactly as written. [R8] [R14]
                  d.regs[slot[3:0]] = byte_in;
                end
              end
              else
              begin
                d.shift_out = read_reg(q.regs, next_addr);
              end
            end
          end
          default:
          begin
            d.state = ST_IDLE;
          end
        endcase
      end
      else if (fall && (q.state == ST_DATA) && q.rd)
      begin
        // Read data changes on the falling edge for the master's next rising edge.
        // Bits leave the top of the shifter; the next address's byte is loaded and follows once the byte is spent.
        d.sdo = q.shift_out[7];
        d.shift_out = {q.shift_out[6:0], 1'b0};
        d.sdo_oe = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      q.state <= ST_IDLE;
      // The clock history starts at the idle level, so no false edge follows reset.
      q.sclk_prev <= 1'b0;
      q.bit_cnt <= 4'h0;
      q.rd <= 1'b0;
      q.addr <= 15'h0000;
      q.shift_in <= 8'h00;
      q.shift_out <= 8'h00;
      q.sdo <= 1'b0;
      q.sdo_oe <= 1'b0;
      q.regs <= {link_param_pkg::NUM_REGS{link_param_pkg::REG_RESET}};
    end
    else
    begin
      q <= d;
    end
  end

  // The output enable rises with the first read bit and stays until the deselect is seen.
  assign spi_sdo_o = q.sdo;
  assign spi_sdo_oe_o = q.sdo_oe;

  // ----------------------------------------
  // Stored fields to the deframer
  // ----------------------------------------

  // Lane count and descrambler control.
  assign descramble_en_o = q.regs[link_param_pkg::IDX_LANE][link_param_pkg::SCRAMBLE_BIT]; // [R1]
  assign lane_count_field_o = low_field(q.regs[link_param_pkg::IDX_LANE]); // [R2]

  // Frame, multiframe and converter counts, all minus one.
  assign frame_octets_field_o = q.regs[link_param_pkg::IDX_FOCT]; // [R3]
  assign multiframe_field_o = low_field(q.regs[link_param_pkg::IDX_MF]); // [R5] [R6]
  assign converter_field_o = q.regs[link_param_pkg::IDX_CONV]; // [R7]

  // Resolution and control bits as software left them.
  assign ctrl_bits_field_o = q.regs[link_param_pkg::IDX_RES][link_param_pkg::TOP_MSB:link_param_pkg::CS_LSB]; // [R8]
  assign resolution_field_o = low_field(q.regs[link_param_pkg::IDX_RES]); // [R8]

  // Subclass and bits per sample.
  assign subclass_o = top_field(q.regs[link_param_pkg::IDX_SUB]); // [R9]
  assign sample_width_field_o = low_field(q.regs[link_param_pkg::IDX_SUB]); // [R9]

  // Version code, its check, and samples per frame.
  assign version_o = top_field(q.regs[link_param_pkg::IDX_VER]); // [R10]
  assign version_ok_o = (version_o == link_param_pkg::VERSION_B); // [R10]
  assign samples_field_o = low_field(q.regs[link_param_pkg::IDX_VER]); // [R10]

  // High density and control words per frame.
  assign high_density_o = q.regs[link_param_pkg::IDX_DENS][link_param_pkg::HD_BIT]; // [R11]
  assign ctrl_words_field_o = low_field(q.regs[link_param_pkg::IDX_DENS]); // [R11]

  // Plain frame size and the per-lane masks.
  assign frame_octets_plain_o = q.regs[link_param_pkg::IDX_FPLN]; // [R4]
  assign deskew_mask_o = q.regs[link_param_pkg::IDX_DESK]; // [R12]
  assign lane_enable_o = q.regs[link_param_pkg::IDX_LEN]; // [R13]

  // ----------------------------------------
  // Decoded counts
  // ----------------------------------------
  // The decode stage adds one clock, so the counts trail their fields by a cycle.
  link_param_decode u_decode (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .lane_reg_i(q.regs[link_param_pkg::IDX_LANE]),
    .foct_reg_i(q.regs[link_param_pkg::IDX_FOCT]),
    .mf_reg_i(q.regs[link_param_pkg::IDX_MF]),
    .conv_reg_i(q.regs[link_param_pkg::IDX_CONV]),
    .ver_reg_i(q.regs[link_param_pkg::IDX_VER]),
    .fpln_reg_i(q.regs[link_param_pkg::IDX_FPLN]),
    .lanes_o(lanes_o),
    .octets_o(octets_o),
    .frames_o(frames_o),
    .converters_o(converters_o),
    .samples_o(samples_o),
    .octets_mismatch_o(octets_mismatch_o)
  );

endmodule : serial_link_param_regs

// ---- link_param_monitor.sv ----
// Assertion checker for the link parameter register bank.
`timescale 1ns/1ps
module link_param_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic spi_csb_n_i,
  input wire logic spi_sdo_oe_o,
  input wire logic descramble_en_o,
  input wire logic [4:0] lane_count_field_o,
  input wire logic [7:0] frame_octets_field_o,
  input wire logic [4:0] multiframe_field_o,
  input wire logic [7:0] converter_field_o,
  input wire logic [2:0] version_o,
  input wire logic version_ok_o,
  input wire logic [4:0] samples_field_o,
  input wire logic high_density_o,
  input wire logic [7:0] frame_octets_plain_o,
  input wire logic [7:0] deskew_mask_o,
  input wire logic [7:0] lane_enable_o,
  input wire logic [5:0] lanes_o,
  input wire logic [8:0] octets_o,
  input wire logic [5:0] frames_o,
  input wire logic [8:0] converters_o,
  input wire logic [5:0] samples_o,
  input wire logic octets_mismatch_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // --------
  // Sequences
  // --------
  // Reset was already released one edge earlier, so the decode stage holds real values.
  sequence settled;
    $past(rst_n_i);
  endsequence
  // Chip select idle long enough for any last byte to have landed.
  sequence csb_idle;
    spi_csb_n_i [*8];
  endsequence
  // --------
  // Decoded counts follow their fields one clock later; version flag and idle-port checks
  // --------
  lanes_follow_a: assert property (settled |-> lanes_o == {1'b0, $past(lane_count_field_o)} + 6'h01)
    else $error("lane count does not follow its field");
  octets_follow_a: assert property (settled |-> octets_o == {1'b0, $past(frame_octets_field_o)} + 9'h001)
    else $error("octet count does not follow its field");
  frames_follow_a: assert property (settled |-> frames_o == {1'b0, $past(multiframe_field_o)} + 6'h01)
    else $error("frame count does not follow its field");
  conv_follow_a: assert property (settled |-> converters_o == {1'b0, $past(converter_field_o)} + 9'h001)
    else $error("converter count does not follow its field");
  samples_follow_a: assert property (settled |-> samples_o == {1'b0, $past(samples_field_o)} + 6'h01)
    else $error("sample count does not follow its field");
  version_flag_a: assert property (version_ok_o == (version_o == 3'h1))
    else $error("version flag disagrees with version field");
  octets_agree_a: assert property (settled |-> octets_mismatch_o ==
    (({1'b0, $past(frame_octets_field_o)} + 9'h001) != {1'b0, $past(frame_octets_plain_o)}))
    else $error("octet mismatch flag is wrong");
  masks_hold_a: assert property (csb_idle |-> $stable(deskew_mask_o) && $stable(lane_enable_o)
    && $stable(descramble_en_o) && $stable(high_density_o))
    else $error("register output moved with the port idle");
  oe_idle_a: assert property (csb_idle |-> !spi_sdo_oe_o)
    else $error("read data driver left on with the port idle");
endmodule : link_param_monitor

bind serial_link_param_regs link_param_monitor u_mon (.mclk_i, .rst_n_i, .spi_csb_n_i, .descramble_en_o,
  .lane_count_field_o, .frame_octets_field_o, .multiframe_field_o, .converter_field_o, .version_o,
  .version_ok_o, .samples_field_o, .high_density_o, .frame_octets_plain_o, .deskew_mask_o, .lane_enable_o,
  .lanes_o, .octets_o, .frames_o, .converters_o, .samples_o, .octets_mismatch_o, .spi_sdo_oe_o);

// ---- spi_host_model.sv ----
// Serial configuration port host that drives the register bank.
`timescale 1ns/1ps
module spi_host_model (
  input wire logic mclk_i,
  input wire logic sdo_i,
  output logic sclk_o,
  output logic csb_n_o,
  output logic sdi_o
);
  // Idle pins: clock still and low, chip deselected.
  initial
  begin
    sclk_o = 1'b0;
    csb_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  // One frame: 16 instruction bits then n bytes, MSB first; phases last 5 mclk to clear the filter.
  // Write bytes come from the top of wd; read bytes collect in the low bits of rdv.
  task automatic frame(input logic rd, input logic [14:0] adr, input int n, input logic [31:0] wd,
    output logic [31:0] rdv);
    logic [47:0] sh;
    sh = {rd, adr, wd};
    rdv = 32'h0;
    @(negedge mclk_i);
    csb_n_o <= 1'b0;
    repeat (5) @(negedge mclk_i);
    for (int i = 0; i < 16 + 8 * n; i++)
    begin
      sdi_o <= sh[47 - i];
      repeat (5) @(negedge mclk_i);
      if (i >= 16)
        rdv = {rdv[30:0], sdo_i};
      sclk_o <= 1'b1;
      repeat (5) @(negedge mclk_i);
      sclk_o <= 1'b0;
    end
    repeat (5) @(negedge mclk_i);
    csb_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (10) @(negedge mclk_i);
  endtask : frame
endmodule : spi_host_model

// ---- tb_top.sv ----
// Self-checking testbench for the link parameter register bank.
`timescale 1ns/1ps
module tb_top;
  logic mclk_i;
  logic rst_n_i;
  logic sclk, csb_n, sdi, sdo, sdo_oe;
  logic descr, hd, vok, mism;
  logic [4:0] lcf, mff, resf, swf, smpf, cwf;
  logic [7:0] focf, convf, fpl, desk, len;
  logic [2:0] subc, ver;
  logic [1:0] csf;
  logic [5:0] lanes, frames, samples;
  logic [8:0] octets, convs;
  logic [31:0] rbuf;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int oe_cycles = 0;
  int oe_mark = 0;
  logic [14:0] adr_t [11] = '{15'h0453, 15'h0454, 15'h0455, 15'h0456, 15'h0457, 15'h0458, 15'h0459,
    15'h045A, 15'h046C, 15'h0476, 15'h047D};
  logic [7:0] dat_t [11] = '{8'h81, 8'h00, 8'h1F, 8'h00, 8'h0F, 8'h2F, 8'h20, 8'h80, 8'h03, 8'h01, 8'h03};

  serial_link_param_regs DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_csb_n_i(csb_n),
    .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe), .descramble_en_o(descr),
    .lane_count_field_o(lcf), .frame_octets_field_o(focf), .multiframe_field_o(mff),
    .converter_field_o(convf), .ctrl_bits_field_o(csf), .resolution_field_o(resf), .subclass_o(subc),
    .sample_width_field_o(swf), .version_o(ver), .version_ok_o(vok), .samples_field_o(smpf),
    .high_density_o(hd), .ctrl_words_field_o(cwf), .frame_octets_plain_o(fpl), .deskew_mask_o(desk),
    .lane_enable_o(len), .lanes_o(lanes), .octets_o(octets), .frames_o(frames), .converters_o(convs),
    .samples_o(samples), .octets_mismatch_o(mism));

  spi_host_model host (.mclk_i(mclk_i), .sdo_i(sdo), .sclk_o(sclk), .csb_n_o(csb_n), .sdi_o(sdi));

  // Free-running 20 MHz clock.
  initial
  begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // Counts read driver cycles and cuts a hung run short well beyond the expected length.
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (sdo_oe === 1'b1)
      oe_cycles <= oe_cycles + 1;
    if (cycles == 30000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  // --------
  // Tasks
  // --------
  // Compares one value and reports a difference at once.
  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Writes n bytes from the top of d, starting at address a.
  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    logic [31:0] r;
    host.frame(1'b0, a, n, d, r);
  endtask : wr

  // Reads one byte and compares it.
  task automatic rd(input logic [14:0] a, input logic [7:0] exp, input string what);
    logic [31:0] r;
    host.frame(1'b1, a, 1, 32'h0, r);
    chk({1'b0, r[7:0]}, {1'b0, exp}, what);
  endtask : rd

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // --------
  // Tests
  // --------
  // Reset, then each scenario in turn.
  initial
  begin
    rst_n_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    foreach (adr_t[i])
      rd(adr_t[i], 8'h00, "reset value");
    chk(9'(lanes), 9'h001, "reset lanes");
    chk(9'(mism), 9'h001, "reset mismatch");
    chk(9'(oe_cycles != 0), 9'h001, "read driver on");
    $display("test done: reset values");
    oe_mark = oe_cycles;
    foreach (adr_t[i])
      wr(adr_t[i], 1, {dat_t[i], 24'h0});
    chk(9'(oe_cycles - oe_mark), 9'h000, "write driver off");
    foreach (adr_t[i])
      rd(adr_t[i], dat_t[i], "mode readback");
    chk(9'(descr), 9'h001, "descramble");
    chk(9'(lanes), 9'h002, "lanes");
    chk(octets, 9'h001, "octets");
    chk(9'(frames), 9'h020, "frames");
    chk(convs, 9'h001, "converters");
    chk(9'({csf, resf}), 9'h00F, "resolution");
    chk(9'({subc, swf}), 9'h02F, "subclass width");
    chk(9'({ver, smpf}), 9'h020, "version samples");
    chk(9'(vok), 9'h001, "version flag");
    chk(9'({hd, cwf}), 9'h020, "density");
    chk(9'(mism), 9'h000, "octets agree");
    chk(9'(desk), 9'h003, "deskew");
    chk(9'(len), 9'h003, "lane enable");
    $display("test done: single converter two lanes");
    wr(15'h0453, 4, 32'h00030F01);
    chk(9'(descr), 9'h000, "descramble off");
    chk(9'(lanes), 9'h001, "one lane");
    chk(octets, 9'h004, "four octets");
    chk(9'(frames), 9'h010, "sixteen frames");
    chk(convs, 9'h002, "two converters");
    chk(9'(mism), 9'h001, "octets differ");
    wr(15'h0476, 1, 32'h04000000);
    chk(9'(mism), 9'h000, "octets agree again");
    host.frame(1'b1, 15'h0454, 2, 32'h0, rbuf);
    chk(9'(rbuf[15:8]), 9'h003, "stream byte 0");
    chk(9'(rbuf[7:0]), 9'h00F, "stream byte 1");
    wr(15'h0459, 1, 32'h41000000);
    chk(9'(vok), 9'h000, "version flag off");
    chk(9'(samples), 9'h002, "two samples");
    wr(15'h0458, 1, 32'h0F000000);
    chk(9'({subc, swf}), 9'h00F, "subclass zero");
    $display("test done: streaming and counts");
    wr(15'h0460, 1, 32'h5A000000);
    rd(15'h0460, 8'h00, "unmapped read");
    rd(15'h045A, 8'h80, "neighbour intact");
    wr(15'h045A, 1, 32'h00000000);
    chk(9'({hd, cwf}), 9'h000, "density off");
    $display("test done: unmapped address");
    conclude();
  end
endmodule : tb_top
